// ==== src/oag_operand_address_generator.v ====
// operand address generator: register file, specifier decode, memory sequencing
// assumes a memory that answers each request with memReady, possibly many cycles later
// What this block does
// - byte operation on a register touches only its low byte
// - autoincrement uses current register as address, advances it afterward
// - step one for bytes, two for words, always two for sp/pc and for deferred modes
// - access addressed by the register completes before the autoincrement pointer update
// - autodecrement lowers register first, then uses the new value
// - index mode adds register to following index word
// - index word fetched from word after instruction before address formed
// - index modes leave index word and register unchanged
// - register deferred uses register as address, register unchanged
// - autoincrement deferred reads pointer word, then adds two
// - autodecrement deferred subtracts two, then reads pointer word
// - index deferred reads pointer word at register plus index
// - result goes to destination location, source left untouched
// - low three bits pick register, upper three the mode, bit three deferred
// - stack pointer always steps by two
// - index word and autoincrement fetches through pc advance pc by two
`include "oag_consts.vh"
`default_nettype none
module oag_operand_address_generator
#(
    parameter WIDTH = 16
)
(
    input  wire             clk,
    input  wire             rstn,
    input  wire             start,
    input  wire             twoOperand,
    input  wire             byteOp,
    input  wire [5:0]       srcSpec,
    input  wire [5:0]       dstSpec,
    input  wire             resultValid,
    input  wire [WIDTH-1:0] resultData,
    input  wire             pcLoad,
    input  wire [WIDTH-1:0] pcLoadValue,
    output reg              memReq,
    output reg              memWrite,
    output reg              memByte,
    output reg  [WIDTH-1:0] memAddr,
    output reg  [WIDTH-1:0] memWdata,
    input  wire [WIDTH-1:0] memRdata,
    input  wire             memReady,
    output reg              busy,
    output reg              srcValid,
    output reg  [WIDTH-1:0] srcOperand,
    output reg  [WIDTH-1:0] dstOperand,
    output reg              done,
    output wire [WIDTH-1:0] pcValue,
    output wire [WIDTH-1:0] spValue
);
    localparam ST_IDLE  = 3'h0;
    localparam ST_IDXW  = 3'h1;
    localparam ST_PTR   = 3'h2;
    localparam ST_OPND  = 3'h3;
    localparam ST_WAITR = 3'h4;
    localparam ST_WRITE = 3'h5;
    localparam ST_DONE  = 3'h6;
    reg [WIDTH-1:0] gpr [0:7];
    reg [2:0]       state_reg;
    reg             phase_reg;     // 0 source, 1 destination
    reg [WIDTH-1:0] ea_reg;
    reg [WIDTH-1:0] dstEa_reg;
    reg             dstInReg_reg;
    reg [2:0]       dstRegSel_reg;
    wire [5:0] spec    = phase_reg ? dstSpec : srcSpec;
    wire [2:0] regSel  = spec[`OAG_REG_MSB:`OAG_REG_LSB];
    wire [2:0] mode    = spec[`OAG_MODE_MSB:`OAG_MODE_LSB];
    wire       deferred = spec[`OAG_DEFER_BIT];
    wire [15:0] step;
    wire [WIDTH-1:0] regVal = gpr[regSel];
    wire [WIDTH-1:0] pcWord = gpr[`OAG_PC_SEL];
    assign pcValue = gpr[`OAG_PC_SEL];
    assign spValue = gpr[`OAG_SP_SEL];
    oag_step u_step
    (
        .mode   (mode),
        .regSel (regSel),
        .byteOp (byteOp),
        .step   (step)
    );
    // register-file write port, one per cycle
    reg             wrEn;
    reg [2:0]       wrSel;
    reg [WIDTH-1:0] wrVal;
    reg             pcBump;
    integer i;
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            for (i = 0; i < 8; i = i + 1)
                gpr[i] <= `OAG_RESET_WORD;
        end
        else
        begin
            if (pcLoad && !busy)
                gpr[`OAG_PC_SEL] <= pcLoadValue;
            else if (pcBump)
                gpr[`OAG_PC_SEL] <= pcWord + `OAG_STEP_WORD;
            if (wrEn && !(pcBump && wrSel == `OAG_PC_SEL))
                gpr[wrSel] <= wrVal;
        end
    end
    // first-cycle action per specifier: decrement, register read, or fetch request
    task startSpec;
        begin
            if (mode == `OAG_MODE_REG)
            begin
                ea_reg <= {{(WIDTH-3){1'b0}}, regSel};
                finishSpec(1'b1, regVal);
            end
            else if (mode == `OAG_MODE_IDX || mode == `OAG_MODE_IDXDEF)
            begin
                memReq   <= 1'b1;
                memByte  <= 1'b0;
                memAddr  <= pcWord;
                state_reg <= ST_IDXW;
            end
            else
            begin
                if (mode == `OAG_MODE_ADEC || mode == `OAG_MODE_ADECDEF)
                    ea_reg <= regVal - step;
                else
                    ea_reg <= regVal;
                memReq    <= 1'b1;
                memByte   <= deferred ? 1'b0 : byteOp;
                memAddr   <= (mode == `OAG_MODE_ADEC || mode == `OAG_MODE_ADECDEF)
                             ? regVal - step : regVal;
                state_reg <= (deferred && mode != `OAG_MODE_REGDEF) ? ST_PTR : ST_OPND;
                if (mode == `OAG_MODE_REGDEF)
                    memByte <= byteOp;
            end
        end
    endtask
    task finishSpec;
        input             inReg;
        input [WIDTH-1:0] value;
        begin
            if (!phase_reg)
            begin
                srcOperand <= value;
                srcValid   <= 1'b1;
                if (twoOperand)
                    phase_reg <= 1'b1;
                else
                begin
                    dstOperand    <= value;
                    dstInReg_reg  <= inReg;
                    dstRegSel_reg <= regSel;
                    state_reg     <= ST_WAITR;
                end
            end
            else
            begin
                dstOperand    <= value;
                dstInReg_reg  <= inReg;
                dstRegSel_reg <= regSel;
                state_reg     <= ST_WAITR;
            end
        end
    endtask
    always @*
    begin
        wrEn   = 1'b0;
        wrSel  = regSel;
        wrVal  = regVal;
        pcBump = 1'b0;
        if (state_reg == ST_IDLE && busy)
        begin
            if (mode == `OAG_MODE_ADEC || mode == `OAG_MODE_ADECDEF)
            begin
                wrEn  = 1'b1;
                wrVal = regVal - step;
            end
        end
        else if (state_reg == ST_IDXW && memReady)
            pcBump = 1'b1;
        else if ((state_reg == ST_PTR || state_reg == ST_OPND) && memReady
                 && (mode == `OAG_MODE_AINC || mode == `OAG_MODE_AINCDEF)
                 && !(state_reg == ST_OPND && mode == `OAG_MODE_AINCDEF))
        begin
            wrEn  = 1'b1;
            wrVal = regVal + step;
        end
        else if (state_reg == ST_WRITE && dstInReg_reg && resultValid)
        begin
            wrEn  = 1'b1;
            wrSel = dstRegSel_reg;
            wrVal = byteOp ? {gpr[dstRegSel_reg][`OAG_HIGH_BYTE], resultData[`OAG_LOW_BYTE]}
                           : resultData;
        end
    end
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            state_reg     <= ST_IDLE;
            phase_reg     <= 1'b0;
            ea_reg        <= `OAG_RESET_WORD;
            dstEa_reg     <= `OAG_RESET_WORD;
            dstInReg_reg  <= 1'b0;
            dstRegSel_reg <= 3'h0;
            memReq        <= 1'b0;
            memWrite      <= 1'b0;
            memByte       <= 1'b0;
            memAddr       <= `OAG_RESET_WORD;
            memWdata      <= `OAG_RESET_WORD;
            busy          <= 1'b0;
            srcValid      <= 1'b0;
            srcOperand    <= `OAG_RESET_WORD;
            dstOperand    <= `OAG_RESET_WORD;
            done          <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (!busy && start)
                    begin
                        busy      <= 1'b1;
                        phase_reg <= 1'b0;
                        srcValid  <= 1'b0;
                    end
                    else if (busy)
                        startSpec;
                end
                ST_IDXW:
                begin
                    if (memReady)
                    begin
                        ea_reg  <= regVal + memRdata;
                        memAddr <= regVal + memRdata;
                        memByte <= deferred ? 1'b0 : byteOp;
                        state_reg <= deferred ? ST_PTR : ST_OPND;
                    end
                end
                ST_PTR:
                begin
                    if (memReady)
                    begin
                        ea_reg    <= memRdata;
                        memAddr   <= memRdata;
                        memByte   <= byteOp;
                        state_reg <= ST_OPND;
                    end
                end
                ST_OPND:
                begin
                    if (memReady)
                    begin
                        memReq <= 1'b0;
                        if (phase_reg || !twoOperand)
                            dstEa_reg <= ea_reg;
                        finishSpec(1'b0, byteOp ? {8'h00, memRdata[`OAG_LOW_BYTE]} : memRdata);
                        if (!phase_reg && twoOperand)
                            state_reg <= ST_IDLE;
                    end
                end
                ST_WAITR:
                    state_reg <= ST_WRITE;
                ST_WRITE:
                begin
                    if (resultValid)
                    begin
                        if (dstInReg_reg)
                            state_reg <= ST_DONE;
                        else
                        begin
                            memReq   <= 1'b1;
                            memWrite <= 1'b1;
                            memByte  <= byteOp;
                            memAddr  <= dstEa_reg;
                            memWdata <= resultData;
                            state_reg <= ST_DONE;
                        end
                    end
                end
                ST_DONE:
                begin
                    if (!memReq || memReady)
                    begin
                        memReq    <= 1'b0;
                        memWrite  <= 1'b0;
                        busy      <= 1'b0;
                        srcValid  <= 1'b0;
                        done      <= 1'b1;
                        state_reg <= ST_IDLE;
                    end
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== src/oag_consts.vh ====
// constants for the operand address generator
// assumes a 16-bit word memory with a simple request/ready handshake
`ifndef OAG_CONSTS_VH
`define OAG_CONSTS_VH
`define OAG_REG_LSB      0
`define OAG_REG_MSB      2
`define OAG_MODE_LSB     3
`define OAG_MODE_MSB     5
`define OAG_DEFER_BIT    3
`define OAG_MODE_REG     3'h0
`define OAG_MODE_REGDEF  3'h1
`define OAG_MODE_AINC    3'h2
`define OAG_MODE_AINCDEF 3'h3
`define OAG_MODE_ADEC    3'h4
`define OAG_MODE_ADECDEF 3'h5
`define OAG_MODE_IDX     3'h6
`define OAG_MODE_IDXDEF  3'h7
`define OAG_SP_SEL       3'h6
`define OAG_PC_SEL       3'h7
`define OAG_STEP_BYTE    16'h0001
`define OAG_STEP_WORD    16'h0002
`define OAG_LOW_BYTE     7:0
`define OAG_HIGH_BYTE    15:8
`define OAG_RESET_WORD   16'h0000
`endif

// ==== src/oag_step.v ====
// pointer step size for one operand specifier
// assumes mode and register select come from a decoded specifier
`include "oag_consts.vh"
`default_nettype none
module oag_step
(
    input  wire [2:0]  mode,
    input  wire [2:0]  regSel,
    input  wire        byteOp,
    output wire [15:0] step
);
    wire forceWord;
    // sp/pc and deferred modes always step whole words
    assign forceWord = (regSel == `OAG_SP_SEL) || (regSel == `OAG_PC_SEL)
                       || mode[0];
    assign step = (byteOp && !forceWord) ? `OAG_STEP_BYTE : `OAG_STEP_WORD;
endmodule
`default_nettype wire

// ==== testbench/oag_props.sv ====
// assertions on the operand address generator's ports
// assumes one clock and the synchronous active-low reset of the block
`default_nettype none
module oag_props (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        start,
    input wire logic        busy,
    input wire logic        twoOperand,
    input wire logic [5:0]  srcSpec,
    input wire logic        memReq,
    input wire logic        memWrite,
    input wire logic [15:0] memAddr,
    input wire logic        memReady,
    input wire logic        done,
    input wire logic [15:0] pcValue,
    input wire logic [15:0] spValue
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [15:0] spHold;
    logic [15:0] pcHold;
    logic [15:0] fetchPc;
    wire logic go = start && !busy && !twoOperand;
    wire logic spSel = srcSpec[2:0] == 3'h6;
    // sp and pc as seen when the operation was taken, and pc as seen at each completed access
    always_ff @(posedge clk)
    begin
        if (start && !busy)
        begin
            spHold <= spValue;
            pcHold <= pcValue;
        end
        if (memReq && memReady)
            fetchPc <= pcValue;
    end
    a_req_hold: assert property (memReq && !memReady |=>
        memReq && $stable(memAddr) && $stable(memWrite)) else $error("request dropped early");
    a_pc_step: assert property (memReq && memReady && !memWrite && memAddr == pcValue
        |-> ##[1:2] pcValue == fetchPc + 16'h0002) else $error("pc fetch step wrong");
    a_regdef_addr: assert property (go && srcSpec == 6'h0e
        |-> ##[1:3] memReq && memAddr == spHold) else $error("deferred address wrong");
    a_ainc_addr: assert property (go && spSel && srcSpec[5:4] == 2'h1
        |-> ##[1:3] memReq && memAddr == spHold) else $error("increment address wrong");
    a_ainc_late: assert property (go && spSel && srcSpec[5:4] == 2'h1 |=>
        (spValue == spHold) throughout (##[0:30] (memReq && memReady)))
        else $error("pointer stepped before access");
    a_adec_addr: assert property (go && spSel && srcSpec[5:4] == 2'h2
        |-> ##[1:3] memReq && memAddr == spHold - 16'h0002) else $error("decrement wrong");
    a_idx_first: assert property (start && !busy && srcSpec[5:4] == 2'h3
        |-> ##[1:3] memReq && memAddr == pcHold) else $error("index word not first");
    a_idx_keep: assert property (go && spSel && srcSpec[5:4] == 2'h3 |=>
        $stable(spValue) throughout (##[0:90] done)) else $error("index changed register");
    a_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
endmodule
bind oag_operand_address_generator oag_props i_props (
    .clk(clk), .rstn(rstn), .start(start), .busy(busy), .twoOperand(twoOperand),
    .srcSpec(srcSpec), .memReq(memReq), .memWrite(memWrite), .memAddr(memAddr),
    .memReady(memReady), .done(done), .pcValue(pcValue), .spValue(spValue));
`default_nettype wire

// ==== testbench/oag_mem_model.sv ====
// word memory answering one request at a time, promptly or slowly
// assumes the requester holds its request until memReady is seen
`default_nettype none
module oag_mem_model (
    input wire logic        clk,
    input wire logic        slow,
    input wire logic        memReq,
    input wire logic        memWrite,
    input wire logic [15:0] memAddr,
    input wire logic [15:0] memWdata,
    output logic     [15:0] memRdata,
    output logic            memReady,
    output logic     [15:0] lastWaddr
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:32767];
    logic [2:0]  waitCnt = 3'h0;
    initial memReady = 1'h0;
    initial memRdata = 16'h0;
    initial lastWaddr = 16'h0;
    always @(posedge clk)
    begin
        memReady <= 1'h0;
        // read data is only valid with memReady, so it churns otherwise
        memRdata <= ~memRdata;
        if (memReq && !memReady)
        begin
            if (waitCnt == (slow ? 3'h5 : 3'h0))
            begin
                waitCnt  <= 3'h0;
                memReady <= 1'h1;
                memRdata <= mem[memAddr[15:1]];
                if (memWrite)
                    lastWaddr <= memAddr;
                if (memWrite)
                    mem[memAddr[15:1]] <= memWdata;
            end
            else
                waitCnt <= waitCnt + 3'h1;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// bench for the operand address generator with a word memory model
// assumes registers start at zero; sp is loaded through register mode, pc through pcLoad
`default_nettype none
`define CHK(nm, e, a) begin checksDone++; if ((a) !== (e)) begin errTotal++; \
    $display("unexpected %s expected %h seen %h", nm, e, a); end end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'h0, rstn = 1'h0, start = 1'h0, twoOperand = 1'h0, byteOp = 1'h0;
    logic resultValid = 1'h1, pcLoad = 1'h0, slow = 1'h0;
    logic [5:0] srcSpec = 6'h0, dstSpec = 6'h0;
    logic [15:0] resultData = 16'h0, pcLoadValue = 16'h0;
    logic memReq, memWrite, memReady, done, busy;
    logic [15:0] memAddr, memWdata, memRdata, lastWaddr, pcValue, spValue, srcOperand;
    int errTotal = 0, checksDone = 0;
    oag_operand_address_generator i_oag_operand_address_generator (.clk(clk),
        .rstn(rstn), .start(start), .twoOperand(twoOperand), .byteOp(byteOp),
        .srcSpec(srcSpec), .dstSpec(dstSpec), .resultValid(resultValid),
        .resultData(resultData), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
        .memReq(memReq), .memWrite(memWrite), .memByte(), .memAddr(memAddr),
        .memWdata(memWdata), .memRdata(memRdata), .memReady(memReady), .busy(busy),
        .srcValid(), .srcOperand(srcOperand), .dstOperand(), .done(done),
        .pcValue(pcValue), .spValue(spValue));
    oag_mem_model i_mem (.clk(clk), .slow(slow), .memReq(memReq), .memWrite(memWrite),
        .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
        .memReady(memReady), .lastWaddr(lastWaddr));
    initial
        forever #5 clk = ~clk;
    task automatic poke(input logic [15:0] a, input logic [15:0] d);
        i_mem.mem[a[15:1]] = d;
    endtask
    task automatic op(input logic two, input logic bo, input logic [5:0] s, d,
                      input logic [15:0] rd);
        int n;
        n = 0;
        twoOperand <= two;
        byteOp     <= bo;
        srcSpec    <= s;
        dstSpec    <= d;
        resultData <= rd;
        start      <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        do
            @(negedge clk);
        while (done !== 1'h1 && ++n < 300);
        `CHK("done", 1'h1, done)
        `CHK("busy", 1'h0, busy)
        repeat (2) @(posedge clk);
    endtask
    task t_reg;
        op(1'h0, 1'h0, 6'h06, 6'h00, 16'h3000);
        `CHK("sp load", 16'h3000, spValue)
        op(1'h0, 1'h1, 6'h06, 6'h00, 16'h12ab);
        `CHK("sp low byte", 16'h30ab, spValue)
        op(1'h0, 1'h0, 6'h06, 6'h00, 16'h3000);
        op(1'h0, 1'h0, 6'h0e, 6'h00, 16'h1111);
        `CHK("deferred addr", 16'h3000, lastWaddr)
        `CHK("deferred sp", 16'h3000, spValue)
    endtask
    task t_ainc;
        poke(16'h3002, 16'h4000);
        op(1'h0, 1'h1, 6'h16, 6'h00, 16'h0055);
        `CHK("inc addr", 16'h3000, lastWaddr)
        `CHK("inc sp", 16'h3002, spValue)
        op(1'h0, 1'h1, 6'h1e, 6'h00, 16'h0055);
        `CHK("inc def addr", 16'h4000, lastWaddr)
        `CHK("inc def sp", 16'h3004, spValue)
    endtask
    task t_adec;
        poke(16'h3000, 16'h5000);
        op(1'h0, 1'h0, 6'h26, 6'h00, 16'h0066);
        `CHK("dec addr", 16'h3002, lastWaddr)
        `CHK("dec operand", 16'h4000, srcOperand)
        op(1'h0, 1'h1, 6'h2e, 6'h00, 16'h0066);
        `CHK("dec def addr", 16'h5000, lastWaddr)
        `CHK("dec def sp", 16'h3000, spValue)
    endtask
    task t_idx;
        poke(16'h0100, 16'h0020);
        poke(16'h0102, 16'h0010);
        poke(16'h3010, 16'h6000);
        slow        <= 1'h1;
        pcLoad      <= 1'h1;
        pcLoadValue <= 16'h0100;
        @(posedge clk);
        pcLoad <= 1'h0;
        @(posedge clk);
        op(1'h0, 1'h0, 6'h36, 6'h00, 16'h0077);
        `CHK("idx addr", 16'h3020, lastWaddr)
        `CHK("idx pc", 16'h0102, pcValue)
        `CHK("idx sp", 16'h3000, spValue)
        op(1'h0, 1'h0, 6'h3e, 6'h00, 16'h0077);
        `CHK("idx def addr", 16'h6000, lastWaddr)
        `CHK("idx def pc", 16'h0104, pcValue)
    endtask
    task t_two;
        poke(16'h0104, 16'h0002);
        poke(16'h0106, 16'h0004);
        poke(16'h3002, 16'h7777);
        op(1'h1, 1'h0, 6'h36, 6'h36, 16'h1234);
        `CHK("src operand", 16'h7777, srcOperand)
        `CHK("dst addr", 16'h3004, lastWaddr)
        `CHK("dst word", 16'h1234, i_mem.mem[15'h1802])
        `CHK("src word", 16'h7777, i_mem.mem[15'h1801])
        `CHK("two pc", 16'h0108, pcValue)
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // well above the few hundred cycles the scenarios need
    initial
    begin
        repeat (5000) @(posedge clk);
        errTotal++;
        print_verdict;
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        t_reg;
        t_ainc;
        t_adec;
        t_idx;
        t_two;
        print_verdict;
    end
endmodule
`default_nettype wire
